// >>> hdl/dim_dac_irq_ctrl.sv
/*
  apb slave for the dac interrupt enable and disable registers,
  plus mask readback, raw source status and the interrupt output.
  assumes source flags are levels on CLK_IN and apb is on CLK_IN.
*/
`timescale 1ns/1ns
`default_nettype none
module dim_dac_irq_ctrl
  import dim_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [31:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [3:0]  SRC_FLAGS_IN,
  output logic             IRQ_OUT,
  output logic      [3:0]  MASK_OUT
);

  // ==========================================================
  // bus phases
  wire setup_ph;
  wire access_ph;
  wire wr_fire;

  assign setup_ph  = PSEL_IN & ~PENABLE_IN;
  assign access_ph = PSEL_IN & PENABLE_IN;
  // no wait states: every access completes in its first cycle
  assign PREADY_OUT = 1'b1;
  assign wr_fire    = access_ph & PWRITE_IN & PREADY_OUT;

  // ==========================================================
  // address decode
  wire hit_en;
  wire hit_dis;
  wire hit_mask;
  wire hit_stat;
  wire hit_any;

  assign hit_en   = dim_hit(PADDR_IN, DIM_ADDR_IRQ_ENABLE);
  assign hit_dis  = dim_hit(PADDR_IN, DIM_ADDR_IRQ_DISABLE);
  assign hit_mask = dim_hit(PADDR_IN, DIM_ADDR_IRQ_MASK);
  assign hit_stat = dim_hit(PADDR_IN, DIM_ADDR_SRC_STATUS);
  assign hit_any  = hit_en | hit_dis | hit_mask | hit_stat;

  // unmapped addresses answer with an error, nothing changes
  assign PSLVERR_OUT = access_ph & ~hit_any;

  // ==========================================================
  // write strobes to the mask bank
  dim_mask_if mif ();

  wire [3:0] wr_bits;

  // only the four source bits are looked at
  assign wr_bits = PWDATA_IN[DIM_NUM_SRC-1:0];

  // bit i of either word maps to source i
  // bit 0 transmit ready
  // bit 1 end of conversion
  // bit 2 transmit buffer end
  // bit 3 transmit buffer empty
  assign mif.set_bits = (wr_fire & hit_en)  ? wr_bits
                                            : DIM_NONE;
  assign mif.clr_bits = (wr_fire & hit_dis) ? wr_bits
                                            : DIM_NONE;

  dim_mask_bank u_bank (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .mif       (mif)
  );

  // ==========================================================
  // read data
  // loaded in the setup cycle so the access phase sees a flop
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  wire  [31:0] rd_word;

  // enable and disable words are write-only and read as zero
  assign rd_word = hit_mask ? {DIM_PAD_ZERO, mif.mask}
                 : hit_stat ? {DIM_PAD_ZERO, SRC_FLAGS_IN}
                 : DIM_WORD_ZERO;
  assign prdata_nxt = (setup_ph & ~PWRITE_IN) ? rd_word : prdata_r;

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      prdata_r <= DIM_WORD_ZERO;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign PRDATA_OUT = prdata_r;

  // ==========================================================
  // interrupt output
  logic irq_r;
  wire  irq_nxt;

  // registered so the pin never glitches on flag edges
  assign irq_nxt = |(SRC_FLAGS_IN & mif.mask);

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign IRQ_OUT  = irq_r;
  assign MASK_OUT = mif.mask;

  // ==========================================================
  // checks on the enable word
  a_enable_sets_mask:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_en) |=>
        ((MASK_OUT & $past(PWDATA_IN[3:0]))
          == $past(PWDATA_IN[3:0])))
    else $error("enable write did not set mask bits");

  a_enable_zero_keeps:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_en) |=>
        (((MASK_OUT ^ $past(MASK_OUT))
          & ~$past(PWDATA_IN[3:0])) == DIM_NONE))
    else $error("enable write moved a zero bit");

  // ==========================================================
  // checks on the disable word
  a_disable_clears_mask:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_dis) |=>
        ((MASK_OUT & $past(PWDATA_IN[3:0])) == DIM_NONE))
    else $error("disable write left mask bits set");

  a_disable_zero_keeps:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_dis) |=>
        (((MASK_OUT ^ $past(MASK_OUT))
          & ~$past(PWDATA_IN[3:0])) == DIM_NONE))
    else $error("disable write moved a zero bit");

  // ==========================================================
  // bit placement checks
  a_tx_ready_route:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_en
        && PWDATA_IN[3:0] == 4'h1)
      |=> MASK_OUT[DIM_BIT_TX_READY]
        ##0 (MASK_OUT[3:1] == $past(MASK_OUT[3:1])))
    else $error("bit 0 did not reach transmit ready");

  a_conv_end_route:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && hit_dis
        && PWDATA_IN[3:0] == 4'h2)
      |=> !MASK_OUT[DIM_BIT_CONV_END]
        ##0 (MASK_OUT[0] == $past(MASK_OUT[0])))
    else $error("bit 1 did not reach end of conversion");

  a_buf_end_irq:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (SRC_FLAGS_IN == 4'h4 && MASK_OUT[DIM_BIT_TXBUF_END])
      |=> IRQ_OUT)
    else $error("transmit buffer end did not raise irq");

  a_buf_empty_quiet:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (SRC_FLAGS_IN == 4'h8 && !MASK_OUT[DIM_BIT_TXBUF_EMPTY])
      |=> !IRQ_OUT)
    else $error("masked buffer empty raised irq");

  // ==========================================================
  // gating and ignored bits
  a_irq_follows_mask:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      $rose(IRQ_OUT) |->
        ($past(SRC_FLAGS_IN) & $past(MASK_OUT)) != DIM_NONE)
    else $error("irq rose with no enabled flag");

  a_high_bits_ignored:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && PWRITE_IN && (hit_en || hit_dis)
        && PWDATA_IN[3:0] == DIM_NONE)
      |=> $stable(MASK_OUT))
    else $error("upper write bits changed the mask");

  a_idle_holds_mask:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !(access_ph && PWRITE_IN) [*2] |-> $stable(MASK_OUT))
    else $error("mask changed without a write");

  // ==========================================================
  // bus answer checks, plus irq low with no enabled flag
  a_read_mask_word:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (setup_ph && !PWRITE_IN && hit_mask) |=>
        (PRDATA_OUT == {DIM_PAD_ZERO, $past(MASK_OUT)}))
    else $error("mask readback wrong");

  // an unmapped access must also leave the mask alone
  a_unmapped_error:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (access_ph && !hit_any) |-> PSLVERR_OUT ##1 $stable(MASK_OUT))
    else $error("unmapped access not flagged or not ignored");

  a_read_stat_word:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (setup_ph && !PWRITE_IN && hit_stat) |=>
        (PRDATA_OUT == {DIM_PAD_ZERO, $past(SRC_FLAGS_IN)}))
    else $error("status readback wrong");

  a_wo_reads_zero:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (setup_ph && !PWRITE_IN && (hit_en || hit_dis)) |=>
        (PRDATA_OUT == DIM_WORD_ZERO))
    else $error("write-only word read back nonzero");

  // read data must not move under a master that samples late
  a_rdata_holds:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !(setup_ph && !PWRITE_IN) |=> $stable(PRDATA_OUT))
    else $error("read data moved outside a read setup");

  a_irq_drops_masked:
    assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ((SRC_FLAGS_IN & MASK_OUT) == DIM_NONE) |=> !IRQ_OUT)
    else $error("irq high with no enabled flag");

endmodule : dim_dac_irq_ctrl
`default_nettype wire

// >>> hdl/dim_mask_bank.sv
/*
  the four interrupt mask bits and their set and clear logic.
  assumes set and clear strobes are one-cycle and already decoded.
*/
`timescale 1ns/1ns
`default_nettype none
module dim_mask_bank
  import dim_pkg::*;
(
  input wire logic   clk_in,
  input wire logic   resetn_in,
  dim_mask_if.bank   mif
);

  // ==========================================================
  // mask update
  logic [3:0] mask_r;
  logic [3:0] mask_nxt;
  wire  [3:0] keep_bits;

  // only bits written as one move; zeros keep state
  assign keep_bits = ~(mif.set_bits | mif.clr_bits);
  // set and clear never come together: one address per access
  assign mask_nxt  = (mask_r & keep_bits)
                   | mif.set_bits;
  assign mif.mask  = mask_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mask_r <= DIM_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ==========================================================
  // checks
  a_clear_drops_bits:
    assert property (@(posedge clk_in) disable iff (!resetn_in)
      (mif.clr_bits != DIM_NONE) |=>
        ((mask_r & $past(mif.clr_bits)) == DIM_NONE))
    else $error("cleared mask bit still set");

  a_set_raises_bits:
    assert property (@(posedge clk_in) disable iff (!resetn_in)
      (mif.set_bits != DIM_NONE) |=>
        ((mask_r & $past(mif.set_bits)) == $past(mif.set_bits)))
    else $error("set mask bit not raised");

endmodule : dim_mask_bank
`default_nettype wire

// >>> hdl/dim_mask_if.sv
/*
  carrier between the apb front end and the mask bank.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface dim_mask_if;
  logic [3:0] set_bits;
  logic [3:0] clr_bits;
  logic [3:0] mask;

  modport ctrl (output set_bits, output clr_bits, input mask);
  modport bank (input set_bits, input clr_bits, output mask);
endinterface : dim_mask_if
`default_nettype wire

// >>> hdl/dim_pkg.sv
/*
  constants for the dac interrupt mask block: register addresses,
  source bit positions, reset values and address decode.
  assumes a 32-bit apb with byte addresses and one word per register.
*/
// What this block does
// - enable write of one sets that mask bit
// - zero bits in either write change nothing
// - disable write of one clears that mask bit
// - bit 0 is the transmit ready source
// - bit 1 is the end of conversion source
// - bit 2 is the transmit buffer end source
// - bit 3 is the transmit buffer empty source
`default_nettype none
package dim_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned DIM_NUM_SRC = 4;
  localparam int unsigned DIM_DATA_W  = 32;
  localparam int unsigned DIM_ADDR_W  = 32;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] DIM_ADDR_IRQ_ENABLE  = 32'h4003c024;
  localparam logic [31:0] DIM_ADDR_IRQ_DISABLE = 32'h4003c028;
  localparam logic [31:0] DIM_ADDR_IRQ_MASK    = 32'h4003c02c;
  localparam logic [31:0] DIM_ADDR_SRC_STATUS  = 32'h4003c030;

  // ==========================================================
  // source bit positions
  localparam int unsigned DIM_BIT_TX_READY   = 0;
  localparam int unsigned DIM_BIT_CONV_END   = 1;
  localparam int unsigned DIM_BIT_TXBUF_END  = 2;
  localparam int unsigned DIM_BIT_TXBUF_EMPTY = 3;

  // ==========================================================
  // reset and fill values
  localparam logic [3:0]  DIM_MASK_RST = 4'h0;
  localparam logic [3:0]  DIM_NONE     = 4'h0;
  localparam logic [31:0] DIM_WORD_ZERO = 32'h0000_0000;
  localparam logic [27:0] DIM_PAD_ZERO  = 28'h000_0000;

  // ==========================================================
  // full address compare, used by several decoders
  function automatic logic dim_hit(input logic [31:0] addr,
                                   input logic [31:0] reg_addr);
    dim_hit = (addr == reg_addr);
  endfunction : dim_hit

endpackage : dim_pkg
`default_nettype wire

// >>> tb/tb_top.sv
/*
  self-checking bench for the dac interrupt mask block, random and corner
  writes over apb with a bench model of the mask.
  assumes dim_pkg; the apb master waits for pready however long it takes.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  fail_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_top;
  import dim_pkg::*;

  // ==========================================================
  // signals
  logic             clk     = 1'b0;
  logic             resetn  = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic      [31:0] paddr   = 32'h0000_0000;
  logic      [31:0] pwdata  = 32'h0000_0000;
  logic      [3:0]  flags   = 4'h0;
  logic      [3:0]  exp_mask;
  logic      [31:0] rdata;
  logic             err;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        irq;
  wire logic [3:0]  mask;
  int               fail_count = 0;
  int               n_tests    = 0;

  always #25 clk = ~clk;

  dim_dac_irq_ctrl uut (
    .CLK_IN       (clk),
    .RESETN_IN    (resetn),
    .PSEL_IN      (psel),
    .PENABLE_IN   (penable),
    .PWRITE_IN    (pwrite),
    .PADDR_IN     (paddr),
    .PWDATA_IN    (pwdata),
    .PRDATA_OUT   (prdata),
    .PREADY_OUT   (pready),
    .PSLVERR_OUT  (pslverr),
    .SRC_FLAGS_IN (flags),
    .IRQ_OUT      (irq),
    .MASK_OUT     (mask)
  );

  // ==========================================================
  // closing
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // expectations, worked out from the rules alone
  function automatic logic [3:0] mask_after(input logic [31:0] a,
                                            input logic [31:0] d,
                                            input logic [3:0]  m);
    if (a == DIM_ADDR_IRQ_ENABLE)
      mask_after = m | d[3:0];
    else if (a == DIM_ADDR_IRQ_DISABLE)
      mask_after = m & ~d[3:0];
    else
      mask_after = m;
  endfunction : mask_after

  function automatic logic irq_exp(input logic [3:0] f,
                                   input logic [3:0] m);
    irq_exp = |(f & m);
  endfunction : irq_exp

  // ==========================================================
  // apb master: holds the request until pready, samples at that edge
  task automatic apb(input logic is_wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no limit here: a hung slave is ended by the watchdog
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // model update, then mask compare once the write edge has landed
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    exp_mask = mask_after(a, d, exp_mask);
    @(negedge clk);
    `CHK(mask, exp_mask)
  endtask : wr

  // irq is one cycle behind flags and mask
  task automatic irq_chk;
    @(posedge clk);
    @(negedge clk);
    `CHK(irq, irq_exp(flags, exp_mask))
  endtask : irq_chk

  // ==========================================================
  // tests
  initial begin
    exp_mask = DIM_MASK_RST;
    void'($urandom(32'h7cc6));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(mask, 4'h0)
    `CHK(irq, 1'b0)
    `CHK(prdata, 32'h0000_0000)
    $display("test reset done");
    // one source at a time, upper bits set to prove they are ignored
    for (int b = 0; b < 4; b++) begin
      wr(DIM_ADDR_IRQ_ENABLE, 32'hffff_fff0 | (32'h1 << b));
      `CHK(mask, 4'h1 << b)
      @(posedge clk) flags <= ~(4'h1 << b);
      irq_chk();
      @(posedge clk) flags <= 4'h1 << b;
      irq_chk();
      wr(DIM_ADDR_IRQ_DISABLE, 32'hffff_fff0 | (32'h1 << b));
      `CHK(mask, 4'h0)
      irq_chk();
    end
    $display("test per-source done");
    // zero bits leave everything alone
    wr(DIM_ADDR_IRQ_ENABLE, 32'h0000_0005);
    wr(DIM_ADDR_IRQ_ENABLE, 32'h0000_0000);
    wr(DIM_ADDR_IRQ_DISABLE, 32'hffff_fff0);
    `CHK(mask, 4'h5)
    // unmapped word refused, mask untouched
    apb(1'b1, 32'h4003c034, 32'h0000_000f);
    `CHK(err, 1'b1)
    wr(32'h4003c034, 32'h0000_000a);
    // the readback word is not writable either
    wr(DIM_ADDR_IRQ_MASK, 32'h0000_000a);
    $display("test zero and unmapped done");
    // readback of the mask, the raw flags and a write-only word
    apb(1'b0, DIM_ADDR_IRQ_MASK, DIM_WORD_ZERO);
    `CHK(rdata, 32'(exp_mask))
    `CHK(err, 1'b0)
    apb(1'b0, DIM_ADDR_SRC_STATUS, DIM_WORD_ZERO);
    `CHK(rdata, 32'(flags))
    apb(1'b0, DIM_ADDR_IRQ_ENABLE, DIM_WORD_ZERO);
    `CHK(rdata, 32'h0000_0000)
    $display("test readback done");
    // irq timing, one cycle late both ways
    @(posedge clk) flags <= 4'h1;
    @(negedge clk);
    `CHK(irq, 1'b0)
    @(negedge clk);
    `CHK(irq, 1'b1)
    @(posedge clk) flags <= 4'h0;
    @(negedge clk);
    `CHK(irq, 1'b1)
    @(negedge clk);
    `CHK(irq, 1'b0)
    $display("test irq timing done");
    // random enable and disable traffic, with idle cycles between the writes
    for (int i = 0; i < 60; i++) begin
      @(posedge clk) flags <= 4'($urandom);
      wr(($urandom & 1) ? DIM_ADDR_IRQ_ENABLE : DIM_ADDR_IRQ_DISABLE,
         $urandom);
      irq_chk();
      if (i % 4 == 0) begin
        apb(1'b0, DIM_ADDR_IRQ_MASK, DIM_WORD_ZERO);
        `CHK(rdata, 32'(exp_mask))
      end
    end
    $display("test random done");
    // reset in mid-run: mask, irq and read data all return to rest
    @(posedge clk) flags <= 4'hf;
    wr(DIM_ADDR_IRQ_ENABLE, 32'h0000_000f);
    apb(1'b0, DIM_ADDR_IRQ_MASK, DIM_WORD_ZERO);
    @(posedge clk) resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    exp_mask = DIM_MASK_RST;
    @(negedge clk);
    `CHK(mask, exp_mask)
    `CHK(irq, 1'b0)
    `CHK(prdata, 32'h0000_0000)
    wr(DIM_ADDR_IRQ_ENABLE, 32'h0000_0002);
    irq_chk();
    $display("test mid-run reset done");
    give_verdict();
  end

  // generous span: the tests need well under 1000 cycles
  initial begin
    #(3000 * 50);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

endmodule : tb_top
`default_nettype wire
